/* src/bcd_cfg.svh */
// Purpose: constants of the bridge configuration command decoder
// Assumes: clk_sys at 50 MHz
// Notes: function codes, settings-byte field positions, configuration reset values, frame byte counts and timing live here
`ifndef BCD_CFG_SVH
`define BCD_CFG_SVH

// Function codes carried in the byte after the slave address
`define BCD_FN_SPI_CFG 8'hf0
`define BCD_FN_INT_CLR 8'hf1
`define BCD_FN_IDLE 8'hf2
`define BCD_FN_PIN_WR 8'hf4
`define BCD_FN_PIN_RD 8'hf5
`define BCD_FN_PIN_EN 8'hf6
`define BCD_FN_PIN_TYPE 8'hf7

// Settings byte fields
`define BCD_ORDER_BIT 5
`define BCD_MODE_HI 3
`define BCD_MODE_LO 2
`define BCD_RATE_HI 1
`define BCD_RATE_LO 0

// Reset values
`define BCD_SPI_CFG_RST 5'h00
`define BCD_LATCH_RST 4'h0
`define BCD_PIN_EN_RST 4'h0
`define BCD_PIN_TYPE_RST 8'h00

// Pin type codes
`define BCD_TYPE_QUASI 2'h0
`define BCD_TYPE_PUSH 2'h1
`define BCD_TYPE_INPUT 2'h2
`define BCD_TYPE_OPEN 2'h3

// Fixed upper part of the slave address; value is arbitrary
`define BCD_ADDR_FIXED 4'h5

// Byte counts of a frame, slave address included
`define BCD_CNT_ADDR 3'h1
`define BCD_CNT_FUNC 3'h2
`define BCD_CNT_ONE_DATA 3'h3
`define BCD_CNT_MAX 3'h4

// Timing
`define BCD_CLK_KHZ 50000
`define BCD_RATE0_KHZ 1843
`define BCD_RATE1_KHZ 461
`define BCD_RATE2_KHZ 115
`define BCD_RATE3_KHZ 58
`define BCD_HALF0 10'((`BCD_CLK_KHZ / (2 * `BCD_RATE0_KHZ)))
`define BCD_HALF1 10'((`BCD_CLK_KHZ / (2 * `BCD_RATE1_KHZ)))
`define BCD_HALF2 10'((`BCD_CLK_KHZ / (2 * `BCD_RATE2_KHZ)))
`define BCD_HALF3 10'((`BCD_CLK_KHZ / (2 * `BCD_RATE3_KHZ)))
`define BCD_STRONG_CYC 2'h2
`define BCD_STRAP_WAIT 2'h3

`endif

/* src/bcd_pkg.sv */
// Purpose: types of the bridge configuration command decoder
// Assumes: bcd_cfg.svh holds the numbers
// Notes: none
package bcd_pkg;

  typedef enum logic [1:0] {
    BCD_WAIT = 2'h0,
    BCD_BITS = 2'h1,
    BCD_ACK = 2'h3,
    BCD_SKIP = 2'h2
  } bcd_link_st_type;

  typedef struct packed {
    logic lsb_first;
    logic clock_idle_level;
    logic clock_sample_phase;
    logic [1:0] clock_rate_select;
  } bcd_spi_cfg_type;

  typedef struct packed {
    logic [3:0] latch;
    logic [3:0] gpio_en;
    logic [7:0] pin_type;
  } bcd_pin_cfg_type;

  typedef struct packed {
    logic drive_o;
    logic drive_oe;
    logic pu_very_weak;
    logic pu_weak;
    logic pu_strong;
  } bcd_pin_drv_type;

endpackage

/* src/bcd_pin_cell.sv */
// Purpose: one select line used as slave select or general-purpose pin
// Assumes: pin_sync is already synchronised to clk_sys
// Notes: all outputs are registered
`timescale 1ns/1ps
`include "bcd_cfg.svh"

module bcd_pin_cell (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic latch,
  input wire logic gpio_en,
  input wire logic [1:0] pin_type,
  input wire logic pin_sync,
  input wire logic select_n_req,
  output bcd_pkg::bcd_pin_drv_type drv
);

  typedef struct packed {
    logic latch_d;
    logic [1:0] strong_cnt;
    bcd_pkg::bcd_pin_drv_type drv;
  } bcd_cell_state_type;

  bcd_cell_state_type state_ff;
  bcd_cell_state_type nxt_state;
  logic quasi;

  assign quasi = gpio_en && (pin_type == `BCD_TYPE_QUASI);
  assign drv = state_ff.drv;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.latch_d = latch;
    nxt_state.drv = '0;
    if (quasi && latch && !state_ff.latch_d) begin
      nxt_state.strong_cnt = `BCD_STRONG_CYC;
    end else if (!quasi || !latch) begin
      nxt_state.strong_cnt = 2'h0;
    end else if (state_ff.strong_cnt != 2'h0) begin
      nxt_state.strong_cnt = state_ff.strong_cnt - 2'h1;
    end
    if (!gpio_en) begin
      nxt_state.drv.drive_o = select_n_req;
      nxt_state.drv.drive_oe = 1'b1;
    end else begin
      case (pin_type)
        `BCD_TYPE_QUASI: begin
          if (!latch) begin
            nxt_state.drv.drive_oe = 1'b1;
          end
          nxt_state.drv.pu_very_weak = latch;
          nxt_state.drv.pu_weak = latch && pin_sync;
          nxt_state.drv.pu_strong = nxt_state.strong_cnt != 2'h0;
        end
        `BCD_TYPE_PUSH: begin
          nxt_state.drv.drive_o = latch;
          nxt_state.drv.drive_oe = 1'b1;
        end
        `BCD_TYPE_OPEN: begin
          nxt_state.drv.drive_oe = !latch;
        end
        default: begin
          nxt_state.drv.drive_oe = 1'b0;
        end
      endcase
      if (nxt_state.drv.pu_strong) begin
        nxt_state.drv.drive_o = 1'b1;
        nxt_state.drv.drive_oe = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

endmodule // bcd_pin_cell

/* src/bcd_top.sv */
// Purpose: two-wire command receiver that decodes configuration functions
// Assumes: scl, sda, select lines and address straps are asynchronous pins
// Notes: SPI transfers, buffer read and reads of the bus are handled elsewhere
`timescale 1ns/1ps
`include "bcd_cfg.svh"

module bcd_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [2:0] addr_strap_i,
  input wire logic spi_done,
  input wire logic [3:0] select_n_req,
  input wire logic [3:0] select_line_i,
  output logic [3:0] select_line_o,
  output logic [3:0] select_line_oe,
  output logic [3:0] pu_very_weak,
  output logic [3:0] pu_weak,
  output logic [3:0] pu_strong,
  output logic int_n_o,
  output logic int_n_oe,
  output bcd_pkg::bcd_spi_cfg_type spi_cfg,
  output logic [9:0] spi_half_period,
  output logic low_power,
  output logic busy,
  output logic [7:0] buf_byte0,
  output logic buf_byte0_wr
);

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [2:0] strap_s1;
    logic [2:0] strap_s2;
    logic [1:0] strap_cnt;
    logic [2:0] strap;
    bcd_pkg::bcd_link_st_type st;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [2:0] byte_cnt;
    logic [7:0] func;
    logic [7:0] data;
    logic ack;
    logic sda_oe;
    logic exec;
    logic int_act;
    logic idle;
    bcd_pkg::bcd_spi_cfg_type spi;
    logic [9:0] half;
    bcd_pkg::bcd_pin_cfg_type pins;
    logic [7:0] sample;
    logic sample_wr;
    logic drain_lvl;
  } bcd_state_type;

  bcd_state_type state_ff;
  bcd_state_type nxt_state;
  bcd_pkg::bcd_pin_drv_type drv [4];
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [6:0] own_addr;

  assign scl_rise = state_ff.scl_s2 && !state_ff.scl_d;
  assign scl_fall = !state_ff.scl_s2 && state_ff.scl_d;
  assign start_seen = state_ff.scl_s2 && state_ff.scl_d && !state_ff.sda_s2 && state_ff.sda_d;
  assign stop_seen = state_ff.scl_s2 && state_ff.scl_d && state_ff.sda_s2 && !state_ff.sda_d;
  assign own_addr = {`BCD_ADDR_FIXED, state_ff.strap};

  always_comb begin
    nxt_state = state_ff;
    nxt_state.scl_s1 = scl_i;
    nxt_state.scl_s2 = state_ff.scl_s1;
    nxt_state.scl_d = state_ff.scl_s2;
    nxt_state.sda_s1 = sda_i;
    nxt_state.sda_s2 = state_ff.sda_s1;
    nxt_state.sda_d = state_ff.sda_s2;
    nxt_state.pin_s1 = select_line_i;
    nxt_state.pin_s2 = state_ff.pin_s1;
    nxt_state.strap_s1 = addr_strap_i;
    nxt_state.strap_s2 = state_ff.strap_s1;
    nxt_state.exec = 1'b0;
    nxt_state.sample_wr = 1'b0;

    // Straps are loaded in the first three cycles after reset, the last load after the synchroniser has filled
    if (state_ff.strap_cnt != `BCD_STRAP_WAIT) begin
      nxt_state.strap_cnt = state_ff.strap_cnt + 2'h1;
      nxt_state.strap = state_ff.strap_s2;
    end

    // Link receiver
    if (stop_seen) begin
      if (state_ff.st != bcd_pkg::BCD_WAIT && state_ff.st != bcd_pkg::BCD_SKIP &&
          state_ff.byte_cnt >= `BCD_CNT_FUNC) begin
        nxt_state.exec = 1'b1;
      end
      nxt_state.st = bcd_pkg::BCD_WAIT;
      nxt_state.sda_oe = 1'b0;
    end else if (start_seen) begin
      nxt_state.bit_cnt = 4'h0;
      nxt_state.byte_cnt = 3'h0;
      nxt_state.sda_oe = 1'b0;
      nxt_state.st = state_ff.exec ? bcd_pkg::BCD_SKIP : bcd_pkg::BCD_BITS;
    end else begin
      case (state_ff.st)
        bcd_pkg::BCD_BITS: begin
          if (scl_rise) begin
            nxt_state.shreg = {state_ff.shreg[6:0], state_ff.sda_s2};
            nxt_state.bit_cnt = state_ff.bit_cnt + 4'h1;
          end else if (scl_fall && state_ff.bit_cnt == 4'h8) begin
            nxt_state.ack = 1'b1;
            if (state_ff.byte_cnt == 3'h0) begin
              if (state_ff.shreg[7:1] == own_addr) begin
                nxt_state.idle = 1'b0;
              end
              // Reads belong to the buffer path, so only writes are taken here
              nxt_state.ack = (state_ff.shreg[7:1] == own_addr) && !state_ff.shreg[0];
            end else if (state_ff.byte_cnt == `BCD_CNT_ADDR) begin
              nxt_state.func = state_ff.shreg;
            end else if (state_ff.byte_cnt == `BCD_CNT_FUNC) begin
              nxt_state.data = state_ff.shreg;
            end
            if (state_ff.byte_cnt != `BCD_CNT_MAX) begin
              nxt_state.byte_cnt = state_ff.byte_cnt + 3'h1;
            end
            nxt_state.sda_oe = nxt_state.ack;
            nxt_state.st = nxt_state.ack ? bcd_pkg::BCD_ACK : bcd_pkg::BCD_SKIP;
          end
        end
        bcd_pkg::BCD_ACK: begin
          if (scl_fall) begin
            nxt_state.sda_oe = 1'b0;
            nxt_state.bit_cnt = 4'h0;
            nxt_state.st = bcd_pkg::BCD_BITS;
          end
        end
        default: begin
          nxt_state.sda_oe = 1'b0;
        end
      endcase
    end

    // Function execution, one cycle after STOP
    if (state_ff.exec) begin
      case (state_ff.func)
        `BCD_FN_SPI_CFG: begin
          if (state_ff.byte_cnt == `BCD_CNT_ONE_DATA) begin
            nxt_state.spi.lsb_first = state_ff.data[`BCD_ORDER_BIT];
            nxt_state.spi.clock_idle_level = state_ff.data[`BCD_MODE_HI];
            nxt_state.spi.clock_sample_phase = state_ff.data[`BCD_MODE_LO];
            nxt_state.spi.clock_rate_select = state_ff.data[`BCD_RATE_HI:`BCD_RATE_LO];
            // bits 7, 6 and 4 are not stored
          end
        end
        `BCD_FN_IDLE: begin
          nxt_state.idle = 1'b1;
        end
        `BCD_FN_PIN_WR: begin
          if (state_ff.byte_cnt == `BCD_CNT_ONE_DATA) begin
            nxt_state.pins.latch = state_ff.data[3:0];
          end
        end
        `BCD_FN_PIN_RD: begin
          // upper nibble left at zero, undefined to the host
          nxt_state.sample = {4'h0, state_ff.pin_s2};
          nxt_state.sample_wr = 1'b1;
        end
        `BCD_FN_PIN_EN: begin
          if (state_ff.byte_cnt == `BCD_CNT_ONE_DATA) begin
            nxt_state.pins.gpio_en = state_ff.data[3:0];
            for (int n = 0; n < 4; n++) begin
              if (state_ff.data[n] && !state_ff.pins.gpio_en[n]) begin
                nxt_state.pins.pin_type[2 * n +: 2] = `BCD_TYPE_QUASI;
              end
            end
          end
        end
        `BCD_FN_PIN_TYPE: begin
          if (state_ff.byte_cnt == `BCD_CNT_ONE_DATA) begin
            nxt_state.pins.pin_type = state_ff.data;
          end
        end
        default: begin
          nxt_state.pins = state_ff.pins;
        end
      endcase
    end

    // half period of the serial clock
    case (nxt_state.spi.clock_rate_select)
      2'h0: nxt_state.half = `BCD_HALF0;
      2'h1: nxt_state.half = `BCD_HALF1;
      2'h2: nxt_state.half = `BCD_HALF2;
      default: nxt_state.half = `BCD_HALF3;
    endcase

    // transfer end sets, clear command clears, set wins
    nxt_state.int_act = (state_ff.int_act &&
                         !(state_ff.exec && state_ff.func == `BCD_FN_INT_CLR)) || spi_done;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '0;
      state_ff.scl_s1 <= 1'b1;
      state_ff.scl_s2 <= 1'b1;
      state_ff.scl_d <= 1'b1;
      state_ff.sda_s1 <= 1'b1;
      state_ff.sda_s2 <= 1'b1;
      state_ff.sda_d <= 1'b1;
      state_ff.st <= bcd_pkg::BCD_WAIT;
      state_ff.spi <= `BCD_SPI_CFG_RST;
      state_ff.half <= `BCD_HALF0;
      state_ff.pins.gpio_en <= `BCD_PIN_EN_RST;
      state_ff.pins.latch <= `BCD_LATCH_RST;
      state_ff.pins.pin_type <= `BCD_PIN_TYPE_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  for (genvar n = 0; n < 4; n++) begin : g_line
    bcd_pin_cell u_cell (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .latch(state_ff.pins.latch[n]),
      .gpio_en(state_ff.pins.gpio_en[n]),
      .pin_type(state_ff.pins.pin_type[2 * n +: 2]),
      .pin_sync(state_ff.pin_s2[n]),
      .select_n_req(select_n_req[n]),
      .drv(drv[n])
    );
    assign select_line_o[n] = drv[n].drive_o;
    assign select_line_oe[n] = drv[n].drive_oe;
    assign pu_very_weak[n] = drv[n].pu_very_weak;
    assign pu_weak[n] = drv[n].pu_weak;
    assign pu_strong[n] = drv[n].pu_strong;
  end

  // Open-drain pins drive only low; the low level is a reset constant flop
  assign sda_o = state_ff.drain_lvl;
  assign sda_oe = state_ff.sda_oe;
  assign int_n_o = state_ff.drain_lvl;
  assign int_n_oe = state_ff.int_act;
  assign spi_cfg = state_ff.spi;
  assign spi_half_period = state_ff.half;
  assign low_power = state_ff.idle;
  assign busy = state_ff.exec;
  assign buf_byte0 = state_ff.sample;
  assign buf_byte0_wr = state_ff.sample_wr;

endmodule // bcd_top

/* tb/bcd_i2c_host.sv */
// Purpose: two-wire bus master that sends command frames to the decoder
// Assumes: bus clock period 160 ns, SDA pulled up outside
// Notes: clock rests high between frames; only acknowledge bits are read back
`timescale 1ns/1ps
module bcd_i2c_host (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic frame(input logic [31:0] data, input int n, output logic [3:0] acks);
    logic [31:0] sh;
    sh = data;
    acks = 4'h0;
    sda_low = 1'b1;
    #80 scl = 1'b0;
    for (int k = 0; k < n; k++) begin
      for (int j = 0; j < 9; j++) begin
        // Data moves only while the clock is low; slot 9 is released for the answer
        #40 sda_low = (j < 8) ? !sh[31] : 1'b0;
        if (j < 8) sh = sh << 1;
        #40 scl = 1'b1;
        #40 if (j == 8) acks[3 - k] = !sda;
        #40 scl = 1'b0;
      end
    end
    #40 sda_low = 1'b1;
    #40 scl = 1'b1;
    #80 sda_low = 1'b0;
    #160;
  endtask
endmodule // bcd_i2c_host

/* tb/bcd_top_sva.sv */
// Purpose: concurrent checks on the decoder's ports
// Assumes: one clock domain, reset rst_n
// Notes: bound to every bcd_top instance
`timescale 1ns/1ps
`include "bcd_cfg.svh"
module bcd_top_sva (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic [2:0] addr_strap_i,
  input wire logic spi_done,
  input wire logic [3:0] select_n_req,
  input wire logic [3:0] select_line_i,
  input wire logic [3:0] select_line_o,
  input wire logic [3:0] select_line_oe,
  input wire logic [3:0] pu_very_weak,
  input wire logic [3:0] pu_weak,
  input wire logic [3:0] pu_strong,
  input wire logic int_n_o,
  input wire logic int_n_oe,
  input wire bcd_pkg::bcd_spi_cfg_type spi_cfg,
  input wire logic [9:0] spi_half_period,
  input wire logic low_power,
  input wire logic busy,
  input wire logic [7:0] buf_byte0,
  input wire logic buf_byte0_wr
);
  logic [9:0] half_of;
  assign half_of = (spi_cfg.clock_rate_select == 2'h0) ? `BCD_HALF0 :
    (spi_cfg.clock_rate_select == 2'h1) ? `BCD_HALF1 :
    (spi_cfg.clock_rate_select == 2'h2) ? `BCD_HALF2 : `BCD_HALF3;
  default clocking dcb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  chk_int_set: assert property (spi_done |=> int_n_oe)
    else $error("interrupt not raised after transfer end");
  chk_int_clear: assert property ($fell(int_n_oe) |-> $past(busy))
    else $error("interrupt dropped without a command");
  chk_drain_zero: assert property (!int_n_o && !sda_o)
    else $error("open-drain output drives high");
  chk_rate_map: assert property ($stable(spi_cfg) |-> spi_half_period == half_of)
    else $error("serial clock half period does not match rate code");
  chk_cfg_quiet: assert property ($changed(spi_cfg) |-> $past(busy))
    else $error("settings changed outside a command");
  chk_busy_pulse: assert property (busy |-> !sda_oe ##1 !busy)
    else $error("bus answered while executing");
  chk_strong_pulse: assert property ($rose(pu_strong[0]) |=>
    (pu_strong[0] && select_line_o[0]) ##1 !pu_strong[0])
    else $error("strong pull-up pulse is not two cycles");
  chk_weak_latch: assert property ((pu_weak & ~pu_very_weak) == 4'h0)
    else $error("weak pull-up on with latch low");
  chk_weak_drop: assert property (!select_line_i[0] [*5] |-> !pu_weak[0])
    else $error("weak pull-up kept on a pin held low");
  chk_sample_time: assert property (buf_byte0_wr |-> $past(busy))
    else $error("pin sample written outside a command");
  chk_idle_entry: assert property ($rose(low_power) |-> $past(busy))
    else $error("idle entered outside a command");
endmodule // bcd_top_sva
bind bcd_top bcd_top_sva bcd_top_sva_inst (.clk_sys, .rst_n, .scl_i, .sda_i, .sda_o, .sda_oe,
  .addr_strap_i, .spi_done, .select_n_req, .select_line_i, .select_line_o, .select_line_oe,
  .pu_very_weak, .pu_weak, .pu_strong, .int_n_o, .int_n_oe, .spi_cfg, .spi_half_period,
  .low_power, .busy, .buf_byte0, .buf_byte0_wr);

/* tb/tb_bcd_top.sv */
// Purpose: self-checking bench of the configuration command decoder
// Assumes: host model sends whole frames; select pins are modelled here
// Notes: seed 5; expectations come from bench functions
`timescale 1ns/1ps
`include "bcd_cfg.svh"
module tb_bcd_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic scl_i, sda_i, sda_o, sda_oe, spi_done, int_n_o, int_n_oe, low_power, busy, buf_byte0_wr;
  logic sda_low;
  logic tog = 1'b0;
  logic [2:0] addr_strap_i = 3'h3;
  logic [3:0] select_n_req, select_line_i, select_line_o, select_line_oe;
  logic [3:0] pu_very_weak, pu_weak, pu_strong, ext_low, acks, lat, en;
  logic [7:0] buf_byte0, r;
  logic [9:0] spi_half_period;
  bcd_pkg::bcd_spi_cfg_type spi_cfg;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  int wr_seen = 0;
  localparam logic [7:0] AW = {`BCD_ADDR_FIXED, 3'h3, 1'b0};
  bcd_top bcd_top_inst (.clk_sys, .rst_n, .scl_i, .sda_i, .sda_o, .sda_oe, .addr_strap_i,
    .spi_done, .select_n_req, .select_line_i, .select_line_o, .select_line_oe, .pu_very_weak,
    .pu_weak, .pu_strong, .int_n_o, .int_n_oe, .spi_cfg, .spi_half_period, .low_power, .busy,
    .buf_byte0, .buf_byte0_wr);
  bcd_i2c_host bcd_i2c_host_inst (.scl(scl_i), .sda_low(sda_low), .sda(sda_i));
  assign sda_i = !(sda_low || sda_oe);
  // Strong drive wins, then an outside low, then a pull-up; a floating pin wanders
  assign select_line_i = (select_line_oe & select_line_o) | (~select_line_oe & ~ext_low &
    (pu_very_weak | pu_weak | pu_strong | {4{tog}}));
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    tog <= ~tog;
    cycles <= cycles + 1;
    if (buf_byte0_wr === 1'b1) wr_seen <= wr_seen + 1;
    if (cycles == 20000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic check_val(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task automatic send(input logic [31:0] d, input int n);
    bcd_i2c_host_inst.frame(d, n, acks);
    tick(1);
  endtask
  function automatic logic [4:0] exp_cfg(input logic [7:0] b);
    return {b[5], b[3], b[2], b[1:0]};
  endfunction
  function automatic logic [9:0] exp_half(input logic [1:0] c);
    return (c == 2'h0) ? 10'd13 : (c == 2'h1) ? 10'd54 : (c == 2'h2) ? 10'd217 : 10'd431;
  endfunction
  // Drive of every line as {oe, o masked by oe} for one type code
  function automatic logic [7:0] exp_drv(input logic [1:0] t, input logic [3:0] l);
    case (t)
      2'h1: return {4'hf, l};
      2'h2: return 8'h00;
      default: return {~l, 4'h0};
    endcase
  endfunction
  initial begin
    spi_done = 1'b0;
    ext_low = 4'h0;
    r = 8'($urandom(5));
    select_n_req = r[3:0];
    tick(2);
    rst_n = 1'b1;
    tick(10);
    check_val({5'h0, spi_cfg}, 10'h0);
    check_val(spi_half_period, 10'd13);
    check_val({6'h0, low_power, int_n_oe, int_n_o, sda_o}, 10'h0);
    check_val({2'h0, select_line_oe, select_line_o}, {6'h0f, select_n_req});
    // Foreign address: no answer, nothing changes
    send({AW ^ 8'h02, `BCD_FN_SPI_CFG, 8'h03, 8'h00}, 3);
    check_val({1'h0, acks, spi_cfg}, 10'h0);
    for (int k = 0; k < 4; k++) begin
      r = (k == 3) ? 8'hff : 8'($urandom);
      r[3:0] = {2'(k), 2'(k)};
      send({AW, `BCD_FN_SPI_CFG, r, 8'h00}, 3);
      check_val({6'h0, acks}, 10'h00e);
      check_val({5'h0, spi_cfg}, {5'h0, exp_cfg(r)});
      check_val(spi_half_period, exp_half(r[1:0]));
    end
    // Two data bytes make the frame void
    send({AW, `BCD_FN_SPI_CFG, 8'h00, 8'h00}, 4);
    check_val({5'h0, spi_cfg}, {5'h0, exp_cfg(8'hff)});
    spi_done = 1'b1;
    tick(1);
    spi_done = 1'b0;
    check_val({9'h0, int_n_oe}, 10'h1);
    // interrupt left set across the next command
    send({AW, `BCD_FN_IDLE, 16'h0}, 2);
    check_val({8'h0, low_power, int_n_oe}, 10'h3);
    send({AW, `BCD_FN_INT_CLR, 16'h0}, 2);
    check_val({6'h0, acks[3], acks[2], low_power, int_n_oe}, 10'h00c);
    send({AW, `BCD_FN_PIN_WR, 8'h00, 8'h00}, 3);
    send({AW, `BCD_FN_PIN_EN, 8'h0f, 8'h00}, 3);
    check_val({2'h0, select_line_oe, select_line_o}, 10'h0f0);
    send({AW, `BCD_FN_PIN_WR, 8'hff, 8'h00}, 3);
    check_val({2'h0, pu_very_weak, select_line_oe}, 10'h0f0);
    r = 8'($urandom);
    // Line 0 stays high in its latch but is held low outside, so its weak pull-up must drop
    r[1] = 1'b0;
    r[0] = 1'b1;
    r[4] = 1'b1;
    lat = r[3:0];
    ext_low = r[7:4];
    send({AW, `BCD_FN_PIN_WR, r, 8'h00}, 3);
    check_val({2'h0, pu_very_weak, select_line_oe & ~select_line_o}, {2'h0, lat, ~lat});
    check_val({6'h0, pu_weak}, {6'h0, lat & ~ext_low});
    // sample command, the host reads the buffer in a later frame
    send({AW, `BCD_FN_PIN_RD, 16'h0}, 2);
    // Upper nibble carries no defined value and is left out
    check_val({6'h0, buf_byte0[3:0]}, {6'h0, lat & ~ext_low});
    check_val(10'(wr_seen), 10'h1);
    ext_low = 4'h0;
    for (int k = 0; k < 4; k++) begin
      r[1:0] = 2'(k ^ 1);
      send({AW, `BCD_FN_PIN_TYPE, {4{r[1:0]}}, 8'h00}, 3);
      check_val({2'h0, select_line_oe, select_line_o & select_line_oe},
        {2'h0, exp_drv(r[1:0], lat)});
    end
    en = 4'($urandom) | 4'h1;
    send({AW, `BCD_FN_PIN_EN, 8'h00, 8'h00}, 3);
    send({AW, `BCD_FN_PIN_EN, {4'h0, en}, 8'h00}, 3);
    check_val({2'h0, select_line_oe, select_line_o & select_line_oe},
      {2'h0, (~lat & en) | ~en, select_n_req & ~en});
    complete_run();
  end
endmodule // tb_bcd_top
